//--- hdl/period_counter.v
// Free-running cycle counter that pulses once each time it reaches its limit
`timescale 1ns/1ps
module period_counter
#(
  parameter WIDTH = 20
)
(
  input  wire             clk,
  input  wire             rstn,
  input  wire             en,
  input  wire             clr,
  input  wire [WIDTH-1:0] limit,
  output reg              done
);

  reg  [WIDTH-1:0] cnt_q;
  wire             at_end;

  assign at_end = (cnt_q == limit - {{(WIDTH-1){1'b0}}, 1'b1});

  // Clear beats counting so a late clear never lets a stale count fire
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= {WIDTH{1'b0}};
      done  <= 1'b0;
    end
    else if (clr || !en)
    begin
      cnt_q <= {WIDTH{1'b0}};
      done  <= 1'b0;
    end
    else if (at_end)
    begin
      cnt_q <= {WIDTH{1'b0}};
      done  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      done  <= 1'b0;
    end
  end

endmodule

//--- hdl/watchdog_sleep_wake_control.v
// Watchdog, sleep entry and wake-up control with AHB-Lite register access
//
// Summary of operation
// - Without prescaler the watchdog times out after one 18 ms base period.
// - Software assigns the prescaler to the watchdog through the option register, up to 1:128.
// - Clear-watchdog and sleep clear the watchdog counter and its assigned prescaler.
// - A watchdog timeout clears the active-low timeout flag.
// - Timeout resets the device when running, wakes it and resumes when asleep.
// - Clearing the watchdog enable bit disables the watchdog for good.
// - Sleep entry clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - While asleep every pin keeps its drive state from before sleep.
// - Sleep ends on master clear, enabled watchdog timeout, or qualifying interrupt.
// - Master clear resets fully; every other wake resumes program execution.
// - Power-down flag sets at power-up and clears on sleep.
// - Only converter-done wakes among peripherals, and only on its own RC clock.
// - While sleep executes the next program word is prefetched.
// - An interrupt wakes only when individually enabled, regardless of global enable.
// - Global enable clear resumes after sleep; set runs next instruction then vectors 0004h.
// - A pending enabled interrupt makes sleep a no-operation with no flag effects.
// - An interrupt during or after sleep lets sleep complete, then wakes at once.
// - Crystal modes wait 1024 oscillator periods on watchdog or interrupt wake; RC modes skip this.
// - With code protection unprogrammed, program memory may be read for verification.
// - Identification words 2000h to 2003h are reachable only in program and verify mode.
`timescale 1ns/1ps
`include "wdt_sleep_defs.vh"
module watchdog_sleep_wake_control
#(
  parameter WDT_BASE_CYCLES = `WDT_BASE_CYCLES,
  parameter OST_CYCLES      = `OST_OSC_PERIODS,
  parameter CONFIG_INIT     = `CONFIG_RESET
)
(
  input  wire        CLK,
  input  wire        RSTN,
  input  wire        HSEL,
  input  wire [15:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        CLEAR_WATCHDOG_INSTRUCTION,
  input  wire        SLEEP_INSTRUCTION,
  input  wire [2:0]  WAKE_FLAGS,
  input  wire [2:0]  WAKE_ENABLES,
  input  wire        ADC_ON_RC_CLOCK,
  input  wire        GLOBAL_INTERRUPT_ENABLE,
  input  wire        MASTER_CLEAR_PIN_N,
  input  wire        PROGRAM_VERIFY_MODE,
  output reg         DEVICE_RESET,
  output reg         OSC_DRIVER_ON,
  output reg         IO_HOLD,
  output reg         PREFETCH_NEXT,
  output reg         RESUME,
  output reg         VECTOR_REQ,
  output reg  [12:0] VECTOR_ADDR,
  output reg         VERIFY_READ_OK,
  output reg         TIMEOUT_FLAG_N,
  output reg         POWERDOWN_FLAG_N
);

  localparam ST_RUN   = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_OST   = 2'd2;

  reg  [1:0]  state_q;
  reg  [7:0]  option_q;
  reg  [7:0]  config_q;
  reg  [13:0] id_mem [0:3];
  reg         wdt_rst_q;
  reg         vec_pend_q;
  reg         pinrst_s1_q;
  reg         pinrst_s2_q;
  reg         pinrst_prev_q;
  reg  [6:0]  presc_q;
  reg         rd_pend_q;
  reg         wr_pend_q;
  reg  [13:0] rd_idx_q;
  reg  [13:0] wr_idx_q;
  reg  [31:0] rd_data;
  wire        base_tick;
  wire        ost_done;
  wire        wdt_on;
  wire        presc_assign;
  wire [2:0]  ps;
  wire [6:0]  ps_mask;
  wire        wdt_timeout;
  wire        wdt_clear;
  wire [2:0]  qual_flags;
  wire        int_pending;
  wire        crystal_mode;
  wire        sleep_take;
  wire        pinrst_fall;
  wire        bus_take;
  wire [13:0] bus_idx;
  wire        id_hit_w;
  wire        id_hit_r;
  integer     k;

  // Pin synchroniser and falling-edge of the master clear pin
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pinrst_s1_q   <= 1'b1;
      pinrst_s2_q   <= 1'b1;
      pinrst_prev_q <= 1'b1;
    end
    else
    begin
      pinrst_s1_q   <= MASTER_CLEAR_PIN_N;
      pinrst_s2_q   <= pinrst_s1_q;
      pinrst_prev_q <= pinrst_s2_q;
    end
  end

  assign pinrst_fall = pinrst_prev_q && !pinrst_s2_q && config_q[`CFG_PIN_RESET_EN];

  // Watchdog configuration decode
  assign wdt_on       = config_q[`CFG_WATCHDOG_EN];
  assign presc_assign = option_q[`OPT_PRESC_ASSIGN];
  assign ps      = option_q[`OPT_PS_HI:`OPT_PS_LO];
  assign ps_mask = (7'h01 << ps) - 7'h01;

  // Wake sources: converter only counts when it runs on its own RC clock
  assign qual_flags   = WAKE_FLAGS &
                        {ADC_ON_RC_CLOCK, 1'b1, 1'b1};
  assign int_pending  = |(qual_flags & WAKE_ENABLES);
  assign crystal_mode = !config_q[`CFG_OSC_SELECT2];

  // Sleep with a pending enabled interrupt degenerates to a no-op
  assign sleep_take = SLEEP_INSTRUCTION && (state_q == ST_RUN) && !int_pending;
  assign wdt_clear  = CLEAR_WATCHDOG_INSTRUCTION || sleep_take;

  // Base period runs from its own divider, standing in for the watchdog oscillator
  period_counter
  #(
    .WIDTH (20)
  )
  u_base
  (
    .clk   (CLK),
    .rstn  (RSTN),
    .en    (wdt_on),
    .clr   (wdt_clear),
    .limit (WDT_BASE_CYCLES[19:0]),
    .done  (base_tick)
  );

  // Oscillator start-up delay, held cleared outside the start-up state
  period_counter
  #(
    .WIDTH (11)
  )
  u_ost
  (
    .clk   (CLK),
    .rstn  (RSTN),
    .en    (state_q == ST_OST),
    .clr   (1'b0),
    .limit (OST_CYCLES[10:0]),
    .done  (ost_done)
  );

  // Timeout on a base tick, or on the last tick of the assigned prescale count
  assign wdt_timeout = base_tick && wdt_on &&
                       (!presc_assign || ((presc_q & ps_mask) == ps_mask));

  // Prescaler; a shortened mask can match early, which is why software clears first
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      presc_q <= 7'h00;
    else if ((wdt_clear && presc_assign) || wdt_timeout)
      presc_q <= 7'h00;
    else if (base_tick && presc_assign)
      presc_q <= presc_q + 7'h01;
  end

  // Sleep, wake and start-up sequencing
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q       <= ST_RUN;
      OSC_DRIVER_ON <= 1'b1;
      IO_HOLD       <= 1'b0;
      PREFETCH_NEXT <= 1'b0;
      RESUME        <= 1'b0;
      VECTOR_REQ    <= 1'b0;
      DEVICE_RESET  <= 1'b0;
      vec_pend_q    <= 1'b0;
      wdt_rst_q     <= 1'b0;
    end
    else
    begin
      PREFETCH_NEXT <= SLEEP_INSTRUCTION && (state_q == ST_RUN);
      RESUME        <= 1'b0;
      VECTOR_REQ    <= 1'b0;
      DEVICE_RESET  <= 1'b0;
      if (pinrst_fall)
      begin
        // Master clear is a full reset from any state
        state_q       <= ST_RUN;
        OSC_DRIVER_ON <= 1'b1;
        IO_HOLD       <= 1'b0;
        DEVICE_RESET  <= 1'b1;
        vec_pend_q    <= 1'b0;
        wdt_rst_q     <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_RUN:
          begin
            if (wdt_timeout)
            begin
              DEVICE_RESET <= 1'b1;
              wdt_rst_q    <= 1'b1;
            end
            else if (sleep_take)
            begin
              state_q       <= ST_SLEEP;
              OSC_DRIVER_ON <= 1'b0;
              IO_HOLD       <= 1'b1;
            end
          end
          ST_SLEEP:
          begin
            // Sleep took full effect the cycle before; an interrupt now just wakes
            if (int_pending || wdt_timeout)
            begin
              vec_pend_q    <= int_pending && !wdt_timeout &&
                               GLOBAL_INTERRUPT_ENABLE;
              OSC_DRIVER_ON <= 1'b1;
              state_q       <= ST_OST;
              if (!crystal_mode)
              begin
                state_q    <= ST_RUN;
                IO_HOLD    <= 1'b0;
                RESUME     <= 1'b1;
                VECTOR_REQ <= int_pending && !wdt_timeout &&
                              GLOBAL_INTERRUPT_ENABLE;
                vec_pend_q <= 1'b0;
              end
            end
          end
          ST_OST:
          begin
            if (ost_done)
            begin
              state_q    <= ST_RUN;
              IO_HOLD    <= 1'b0;
              RESUME     <= 1'b1;
              VECTOR_REQ <= vec_pend_q;
              vec_pend_q <= 1'b0;
            end
          end
          default:
          begin
            state_q <= ST_RUN;
          end
        endcase
      end
    end
  end

  // Status flags; a timeout wins over a sleep set of the same cycle
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      TIMEOUT_FLAG_N   <= 1'b1;
      POWERDOWN_FLAG_N <= 1'b1;
    end
    else
    begin
      if (wdt_timeout)
        TIMEOUT_FLAG_N <= 1'b0;
      else if (sleep_take || CLEAR_WATCHDOG_INSTRUCTION)
        TIMEOUT_FLAG_N <= 1'b1;
      if (sleep_take)
        POWERDOWN_FLAG_N <= 1'b0;
      else if (CLEAR_WATCHDOG_INSTRUCTION)
        POWERDOWN_FLAG_N <= 1'b1;
    end
  end

  // Fixed vector and verify permission from the protection bits
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      VECTOR_ADDR    <= 13'h0000;
      VERIFY_READ_OK <= 1'b0;
    end
    else
    begin
      VECTOR_ADDR    <= `INT_VECTOR;
      VERIFY_READ_OK <= config_q[`CFG_PROTECT_HI] && config_q[`CFG_PROTECT_LO];
    end
  end

  // Bus address phase decode; byte address is four times the index
  assign bus_take = HSEL && HREADY && HTRANS[1] && HREADYOUT;
  assign bus_idx  = HADDR[15:2];
  assign id_hit_w = (wr_idx_q >= `IDX_ID_FIRST) && (wr_idx_q <= `IDX_ID_LAST) &&
                    PROGRAM_VERIFY_MODE;
  assign id_hit_r = (rd_idx_q >= `IDX_ID_FIRST) && (rd_idx_q <= `IDX_ID_LAST) &&
                    PROGRAM_VERIFY_MODE;

  // Read mux; unmapped and locked locations read as zero
  always @*
  begin
    rd_data = 32'h00000000;
    if (rd_idx_q == `IDX_STATUS)
    begin
      rd_data[`ST_SLEEPING]  = IO_HOLD;
      rd_data[`ST_WDT_RESET] = wdt_rst_q;
      rd_data[`ST_POWERDOWN_N] = POWERDOWN_FLAG_N;
      rd_data[`ST_TIMEOUT_N]   = TIMEOUT_FLAG_N;
    end
    else if (rd_idx_q == `IDX_OPTION)
      rd_data[7:0] = option_q;
    else if (rd_idx_q == `IDX_CONFIG)
      rd_data[7:0] = config_q;
    else if (id_hit_r)
      rd_data[13:0] = id_mem[rd_idx_q[1:0]];
  end

  // Bus slave: writes land in the data phase, reads take one wait state
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      rd_idx_q  <= 14'h0000;
      wr_idx_q  <= 14'h0000;
    end
    else
    begin
      HRESP     <= 1'b0;
      wr_pend_q <= 1'b0;
      if (rd_pend_q)
      begin
        HRDATA    <= rd_data;
        HREADYOUT <= 1'b1;
        rd_pend_q <= 1'b0;
      end
      else if (bus_take && !HWRITE)
      begin
        rd_idx_q  <= bus_idx;
        rd_pend_q <= 1'b1;
        HREADYOUT <= 1'b0;
      end
      else if (bus_take)
      begin
        wr_idx_q  <= bus_idx;
        wr_pend_q <= 1'b1;
      end
    end
  end

  // Software-writable registers; the enable fuse can only be cleared
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      option_q <= `OPTION_RESET;
      config_q <= CONFIG_INIT[7:0];
      for (k = 0; k < 4; k = k + 1)
        id_mem[k] <= `ID_RESET;
    end
    else if (wr_pend_q)
    begin
      if (wr_idx_q == `IDX_OPTION)
        option_q <= HWDATA[7:0];
      else if (wr_idx_q == `IDX_CONFIG)
      begin
        config_q                <= HWDATA[7:0];
        config_q[`CFG_WATCHDOG_EN] <= config_q[`CFG_WATCHDOG_EN] & HWDATA[`CFG_WATCHDOG_EN];
      end
      else if (id_hit_w)
        id_mem[wr_idx_q[1:0]] <= HWDATA[13:0];
    end
  end

endmodule

//--- hdl/wdt_sleep_defs.vh
// Register offsets, field positions, reset values and timing for the watchdog and sleep controller
`ifndef WDT_SLEEP_DEFS_VH
`define WDT_SLEEP_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_STATUS        14'h0003
`define IDX_OPTION        14'h0081
`define IDX_ID_FIRST      14'h2000
`define IDX_ID_LAST       14'h2003
`define IDX_CONFIG        14'h2007

// Status fields
`define ST_SLEEPING       0
`define ST_WDT_RESET      1
`define ST_POWERDOWN_N    3
`define ST_TIMEOUT_N      4

// Option fields
`define OPT_PRESC_ASSIGN  3
`define OPT_PS_HI         2
`define OPT_PS_LO         0

// Configuration fields
`define CFG_PIN_RESET_EN  7
`define CFG_PROTECT_HI    6
`define CFG_PROTECT_LO    5
`define CFG_PWRUP_TMR_EN  4
`define CFG_WATCHDOG_EN   3
`define CFG_OSC_SELECT2   2

// Reset values
`define OPTION_RESET      8'hFF
`define CONFIG_RESET      8'hFF
`define ID_RESET          14'h3FFF

// Wake-up source bit positions
`define WK_EXT_EDGE       0
`define WK_PORT_CHANGE    1
`define WK_ADC_DONE       2

// Interrupt vector
`define INT_VECTOR        13'h0004

// Timing: clock rate, base watchdog period, start-up delay
`define CLK_HZ            20000000
`define WDT_BASE_MS       18
`define WDT_BASE_CYCLES   ((`CLK_HZ / 1000) * `WDT_BASE_MS)
`define OST_OSC_PERIODS   1024

`endif

//--- sim/core_model.sv
// Behavioural core sequencer issuing clear-watchdog and sleep pulses
`timescale 1ns/1ps
module core_model
(
  input  wire  CLK,
  output logic CLEAR_WATCHDOG_INSTRUCTION,
  output logic SLEEP_INSTRUCTION
);
  initial
  begin
    CLEAR_WATCHDOG_INSTRUCTION = 1'b0;
    SLEEP_INSTRUCTION = 1'b0;
  end
  // Callers clear before any prescale change
  task clr;
    @(posedge CLK);
    CLEAR_WATCHDOG_INSTRUCTION <= 1'b1;
    @(posedge CLK);
    CLEAR_WATCHDOG_INSTRUCTION <= 1'b0;
  endtask
  // One-cycle sleep; returns at the edge that takes it
  task slp;
    @(posedge CLK);
    SLEEP_INSTRUCTION <= 1'b1;
    @(posedge CLK);
    SLEEP_INSTRUCTION <= 1'b0;
  endtask
endmodule

//--- sim/wake_control_asserts.sv
// Concurrent checks on the watchdog and sleep controller ports
`timescale 1ns/1ps
module wake_control_asserts
#(
  parameter OST_CYCLES = 8
)
(
  input wire        CLK,
  input wire        RSTN,
  input wire        HSEL,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire        HREADY,
  input wire        HREADYOUT,
  input wire        SLEEP_INSTRUCTION,
  input wire [2:0]  WAKE_FLAGS,
  input wire [2:0]  WAKE_ENABLES,
  input wire        ADC_ON_RC_CLOCK,
  input wire        OSC_DRIVER_ON,
  input wire        IO_HOLD,
  input wire        PREFETCH_NEXT,
  input wire        RESUME,
  input wire        VECTOR_REQ,
  input wire [12:0] VECTOR_ADDR,
  input wire        TIMEOUT_FLAG_N,
  input wire        POWERDOWN_FLAG_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Converter wake only counts on its own RC clock
  wire        pend   = |(WAKE_FLAGS & WAKE_ENABLES & {ADC_ON_RC_CLOCK, 2'b11});
  wire        asleep = IO_HOLD && !OSC_DRIVER_ON;
  logic [7:0] ost_q;
  // Start-up wait length, saturating so a hang cannot wrap
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ost_q <= 8'h00;
    else if (IO_HOLD && OSC_DRIVER_ON)
      ost_q <= ost_q + {7'h00, ost_q != 8'hFF};
    else
      ost_q <= 8'h00;
  end
  sequence read_req;
    HSEL && HREADY && HTRANS[1] && !HWRITE && HREADYOUT;
  endsequence
  sequence read_ans;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  read_wait_a: assert property (read_req |=> read_ans)
    else $error("read wait state wrong");
  sleep_entry_a: assert property (SLEEP_INSTRUCTION && !IO_HOLD && !pend |=>
    !POWERDOWN_FLAG_N && TIMEOUT_FLAG_N && !OSC_DRIVER_ON && IO_HOLD) else $error("sleep entry wrong");
  sleep_nop_a: assert property (SLEEP_INSTRUCTION && !IO_HOLD && pend |=>
    $stable(POWERDOWN_FLAG_N) && !IO_HOLD) else $error("pending sleep not a nop");
  prefetch_next_a: assert property (SLEEP_INSTRUCTION && !IO_HOLD |=> PREFETCH_NEXT)
    else $error("no prefetch");
  vector_pair_a: assert property (VECTOR_REQ |-> RESUME && VECTOR_ADDR == 13'h0004)
    else $error("vector without resume");
  hold_cause_a: assert property ($rose(IO_HOLD) |-> $past(SLEEP_INSTRUCTION))
    else $error("pin hold without sleep");
  wake_prompt_a: assert property (asleep && pend |=> RESUME || OSC_DRIVER_ON)
    else $error("enabled interrupt did not wake");
  ost_late_a: assert property (ost_q <= OST_CYCLES + 4)
    else $error("start-up wait too long");
  ost_early_a: assert property (RESUME && ost_q != 0 |-> ost_q >= OST_CYCLES - 1)
    else $error("start-up wait too short");
endmodule

bind watchdog_sleep_wake_control wake_control_asserts #(.OST_CYCLES(OST_CYCLES)) chk (.*);

//--- sim/watchdog_sleep_wake_control_test.sv
// Self-checking bench for the watchdog and sleep controller
`timescale 1ns/1ps
module watchdog_sleep_wake_control_test;
  localparam OST = 8;
  logic        CLK, RSTN, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, ADC_ON_RC_CLOCK, GLOBAL_INTERRUPT_ENABLE;
  logic        MASTER_CLEAR_PIN_N, PROGRAM_VERIFY_MODE, DEVICE_RESET, OSC_DRIVER_ON, IO_HOLD, PREFETCH_NEXT;
  logic        RESUME, VECTOR_REQ, VERIFY_READ_OK, TIMEOUT_FLAG_N, POWERDOWN_FLAG_N;
  logic        CLEAR_WATCHDOG_INSTRUCTION, SLEEP_INSTRUCTION, r, dr, v;
  logic [15:0] HADDR;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE, WAKE_FLAGS, WAKE_ENABLES;
  logic [31:0] HWDATA, HRDATA, q;
  logic [12:0] VECTOR_ADDR;
  int          failures, n_checks, cyc, n;
  assign HREADY = HREADYOUT;
  watchdog_sleep_wake_control #(.WDT_BASE_CYCLES(40), .OST_CYCLES(OST)) dut (.*);
  core_model core (.*);
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // One single AHB transfer; address held until accepted
  task xfer(input logic w, input [15:0] a, input [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1; HADDR <= a; HTRANS <= 2'h2; HWRITE <= w;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    HSEL <= 1'b0; HTRANS <= 2'h0; HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'b1) @(posedge CLK);
    q = HRDATA;
    chk(HRESP === 1'b0, "response not okay");
  endtask
  // Waits for a resume or reset pulse, counting edges
  task wait_ev(input int lim);
    n = 0; r = 0; dr = 0;
    repeat (lim)
    begin
      @(posedge CLK);
      n++;
      r = RESUME; dr = DEVICE_RESET; v = VECTOR_REQ;
      if (r === 1'b1 || dr === 1'b1) break;
    end
  endtask
  task t_regs;
    xfer(0, 16'h0204, 0); chk(q === 32'h000000FF, "option reset");
    xfer(0, 16'h801C, 0); chk(q === 32'h000000FF && VERIFY_READ_OK === 1'b1, "config");
    xfer(0, 16'h000C, 0); chk(q === 32'h00000018, "status after power-up");
    xfer(1, 16'h0100, 32'h5); xfer(0, 16'h0100, 0); chk(q === 32'h0, "unmapped");
    xfer(0, 16'h8000, 0); chk(q === 32'h0, "id visible in run");
    PROGRAM_VERIFY_MODE <= 1'b1;
    xfer(0, 16'h800C, 0); chk(q === 32'h00003FFF, "id reset");
    xfer(1, 16'h800C, 32'h9); xfer(0, 16'h800C, 0); chk(q === 32'h9, "id write");
    PROGRAM_VERIFY_MODE <= 1'b0;
  endtask
  task t_period;
    core.clr(); xfer(1, 16'h0204, 32'h07); core.clr(); wait_ev(60);
    chk(dr === 1'b1 && n >= 38 && n <= 43, "base period");
    chk(TIMEOUT_FLAG_N === 1'b0, "timeout flag");
    core.clr(); xfer(1, 16'h0204, 32'h0A); core.clr(); repeat (100) @(posedge CLK);
    core.clr(); wait_ev(200); chk(dr === 1'b1 && n >= 158 && n <= 163, "prescaled period");
    core.clr(); xfer(1, 16'h0204, 32'h0F); core.clr();
  endtask
  task t_irq;
    for (int g = 0; g < 2; g++)
      for (int s = 0; s < 3; s++)
      begin
        core.clr(); core.slp(); @(posedge CLK);
        chk(!POWERDOWN_FLAG_N && TIMEOUT_FLAG_N && IO_HOLD && !OSC_DRIVER_ON, "sleep entry");
        WAKE_FLAGS <= 3'h1 << s; WAKE_ENABLES <= (s == 2) ? 3'h4 : 3'h0;
        ADC_ON_RC_CLOCK <= 1'b0; GLOBAL_INTERRUPT_ENABLE <= g[0];
        repeat (4) @(posedge CLK);
        chk(IO_HOLD === 1'b1, "unqualified wake");
        WAKE_ENABLES <= 3'h1 << s; ADC_ON_RC_CLOCK <= 1'b1;
        wait_ev(5); chk(r === 1'b1 && v === g[0], "interrupt wake");
        WAKE_FLAGS <= 3'h0; WAKE_ENABLES <= 3'h0;
      end
  endtask
  task t_nop;
    core.clr(); WAKE_FLAGS <= 3'h1; WAKE_ENABLES <= 3'h1; core.slp(); @(posedge CLK);
    chk(POWERDOWN_FLAG_N === 1'b1 && IO_HOLD === 1'b0, "sleep not a nop");
    WAKE_FLAGS <= 3'h0; core.slp(); WAKE_FLAGS <= 3'h1; @(posedge CLK);
    chk(POWERDOWN_FLAG_N === 1'b0, "late interrupt cut sleep");
    wait_ev(5); chk(r === 1'b1, "late interrupt wake");
    WAKE_FLAGS <= 3'h0; WAKE_ENABLES <= 3'h0;
  endtask
  task t_osc;
    xfer(1, 16'h801C, 32'hFB); core.clr(); core.slp(); WAKE_FLAGS <= 3'h2; WAKE_ENABLES <= 3'h2;
    wait_ev(20); chk(r === 1'b1 && n >= OST && n <= OST + 5, "start-up delay");
    WAKE_FLAGS <= 3'h0; WAKE_ENABLES <= 3'h0; xfer(1, 16'h801C, 32'hFF);
  endtask
  task t_sleep_ends;
    core.clr(); xfer(1, 16'h0204, 32'h08); core.slp(); wait_ev(60); @(posedge CLK);
    chk(r === 1'b1 && dr === 1'b0 && TIMEOUT_FLAG_N === 1'b0, "watchdog wake");
    core.clr(); xfer(1, 16'h0204, 32'h0F); core.clr(); core.slp();
    MASTER_CLEAR_PIN_N <= 1'b0; wait_ev(8); chk(dr === 1'b1, "master clear");
    MASTER_CLEAR_PIN_N <= 1'b1; @(posedge CLK); chk(IO_HOLD === 1'b0, "still asleep");
  endtask
  task t_off;
    core.clr(); xfer(1, 16'h801C, 32'hF7); xfer(1, 16'h0204, 32'h08);
    wait_ev(200); chk(dr === 1'b0, "disabled watchdog fired");
    xfer(1, 16'h801C, 32'hFF); xfer(0, 16'h801C, 0); chk(q === 32'h000000F7, "enable came back");
    wait_ev(100); chk(dr === 1'b0, "watchdog revived");
  endtask
  // Hang guard, well above the fewer than one thousand cycles used
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      $display("mismatch at %0t: run hung", $time);
      conclude;
    end
  end
  initial
  begin
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = 0;
    HSIZE = 3'h2; WAKE_FLAGS = 3'h0; WAKE_ENABLES = 3'h0; ADC_ON_RC_CLOCK = 1'b0;
    GLOBAL_INTERRUPT_ENABLE = 1'b0; MASTER_CLEAR_PIN_N = 1'b1; PROGRAM_VERIFY_MODE = 1'b0;
    RSTN = 1'b0; failures = 0; n_checks = 0; cyc = 0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    t_regs; t_period; t_irq; t_nop; t_osc; t_sleep_ends; t_off;
    conclude;
  end
endmodule
